/* File: rtl/psb_pwm_defs.svh */
// constants for the phase-shift bridge pwm logic
// assumes a 40 MHz system clock; included by bare name
`ifndef PSB_PWM_DEFS_SVH
`define PSB_PWM_DEFS_SVH
`define CLK_PERIOD_NS     25
`define PHASE_W           8
`define DEAD_W            8
`define PHASE_RESET       8'h00
`define PHASE_LAST        8'h01
`define DEAD_RESET        8'h00
`define NOLOAD_OFF_MV     500
`define NOLOAD_ON_MV      600
`define ADAPT_MAX_RATIO   4
`endif

/* File: rtl/psb_pwm_pkg.sv */
// types for the phase-shift bridge pwm logic
// no dependencies
package psb_pwm_pkg;
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_RUN  = 2'b01,
        ST_STOP = 2'b11
    } fault_state_e;
endpackage

/* File: rtl/phase_shift_bridge_pwm.sv */
// phase-shift full-bridge pwm digital core
// assumes analog comparators arrive as flags synchronous to clk_i
// assumes the sync pad comparator already applies its hysteresis
// every output is a flop, so a fault kill lands one edge after the flag
// Overview of operation
// [R1] legs complementary when dead time zero
// [R2] first pair toggles at half oscillator rate
// [R3] second pair mirrors first pair behaviour
// [R4] second pair delayed by programmable phase
// [R5] duty may differ while phase moves
// [R6] shutdown on disable, reference loss, undervoltage
// [R7] pull soft-start pin low on ref/uv
// [R8] overcurrent starts soft stop, sink 10x
// [R9] soft stop ends below 0.5V, soft start
// [R10] faults force outputs low immediately
// [R11] source current while pin held low
// [R12] low supply current only in undervoltage
// [R13] soft start after fault, uv, soft stop
// [R14] clamp error amp to soft-start pin
// [R15] drive sync pin with internal clock
// [R16] external sync replaces internal oscillator
// [R17] sync pulse discharges timing ramp
// [R18] sync pin hysteresis between thresholds
// [R19] reference off only in undervoltage
// [R20] per-leg programmable dead time
// [R21] adaptive dead time shrinks up to 4:1
// [R22] no-load stop below 500, resume 600mV
// [R23] analog thresholds are synchronous flags
// [R24] restart from defined phase on soft start
`timescale 1ns/1ps
`include "psb_pwm_defs.svh"

module phase_shift_bridge_pwm
    import psb_pwm_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 osc_tick_i,
    input  wire logic                 sync_in_i,
    input  wire logic                 sync_is_input_i,
    input  wire logic [`PHASE_W-1:0]  phase_i,
    input  wire logic [`DEAD_W-1:0]   leg1_dead_time_i,
    input  wire logic [`DEAD_W-1:0]   leg2_dead_time_i,
    input  wire logic                 adaptive_full_i,
    input  wire logic [1:0]           load_level_i,
    input  wire logic                 softstart_low_i,
    input  wire logic                 reference_low_i,
    input  wire logic                 undervoltage_lockout_i,
    input  wire logic                 overcurrent_i,
    input  wire logic                 error_amp_low_i,
    input  wire logic                 error_amp_high_i,
    output logic                      bridge_a_drive_o,
    output logic                      bridge_b_drive_o,
    output logic                      bridge_c_drive_o,
    output logic                      bridge_d_drive_o,
    output logic                      sync_out_o,
    output logic                      sync_oe_n_o,
    output logic                      ss_pulldown_o,
    output logic                      ss_source_o,
    output logic                      ss_sink10_o,
    output logic                      ea_clamp_o,
    output logic                      ramp_discharge_o,
    output logic                      low_power_o,
    output logic                      reference_enable_o
);

    // fault sequencing state
    fault_state_e       state;
    fault_state_e       next_state;
    logic               hard_fault;
    logic               tick;
    logic               sync_level;
    logic               phase_a;
    logic               phase_c;
    logic [`PHASE_W-1:0] ph_cnt;
    logic               noload_off;
    logic               run_ok;
    // per-leg dead time after load scaling, and its counters
    logic [`DEAD_W-1:0] dead_ab;
    logic [`DEAD_W-1:0] dead_cd;
    logic [`DEAD_W-1:0] cnt_ab;
    logic [`DEAD_W-1:0] cnt_cd;
    // gate commands ahead of the final fault gating flop
    logic               a_q;
    logic               b_q;
    logic               c_q;
    logic               d_q;

    // adaptive scaling: full modulation divides dead time by 1..4 with load
    function automatic logic [`DEAD_W-1:0] adapt(input logic [`DEAD_W-1:0] d,
                                                 input logic en,
                                                 input logic [1:0] lvl);
        logic [`DEAD_W-1:0] r;
        r = d;
        if (en) begin
            case (lvl)
                2'h0:    r = d;
                2'h1:    r = d - (d >> 2);
                2'h2:    r = d >> 1;
                default: r = d >> 2; // 4:1 at peak load
            endcase
        end
        return r;
    endfunction

    // shared kill decode for all four gates; any fault drops them at the next edge
    function automatic logic gate_ok(input logic q,
                                     input logic run,
                                     input logic hard,
                                     input logic oc);
        logic r;
        r = q & run & ~hard & ~oc;
        return r;
    endfunction

    // analog flags are already synchronous comparator outputs
    // softstart_low_i stands for the pin under its disable level;
    // overcurrent is not a hard fault: it takes the soft stop path
    assign hard_fault = softstart_low_i | reference_low_i | undervoltage_lockout_i; // [R6] [R23]

    // external sync overrides internal tick; hysteresis lives in the pad comparator
    // the edge detect gives one tick per sync pulse however wide it is
    assign tick = sync_is_input_i ? (sync_in_i & ~sync_level) : osc_tick_i; // [R16] [R18]

    // both legs share the load estimate, each keeps its own base delay
    assign dead_ab = adapt(leg1_dead_time_i, adaptive_full_i, load_level_i); // [R20] [R21]
    assign dead_cd = adapt(leg2_dead_time_i, adaptive_full_i, load_level_i); // [R20] [R21]

    // no-load latch also holds the bridge quiet
    assign run_ok = (state == ST_RUN) & ~noload_off;

    // fault sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                // soft start begins once every hard fault has cleared
                if (!hard_fault) begin
                    next_state = ST_RUN; // [R13]
                end
            end
            ST_RUN: begin
                if (hard_fault) begin
                    next_state = ST_OFF;
                end else if (overcurrent_i) begin
                    next_state = ST_STOP; // [R8]
                end
            end
            ST_STOP: begin
                // pin discharged below its threshold: stop over, restart
                if (hard_fault) begin
                    next_state = ST_OFF; // [R9]
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // previous sync level for edge detect
    // reset low matches the idle pull-down, so no false edge after reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_level <= 1'b0;
        end else begin
            sync_level <= sync_in_i;
        end
    end

    // no-load comparator with hysteresis
    // starts off: the loop must prove itself before the bridge runs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            noload_off <= 1'b1;
        end else if (error_amp_low_i) begin
            noload_off <= 1'b1; // [R22]
        end else if (error_amp_high_i) begin
            noload_off <= 1'b0; // [R22]
        end
    end

    // half-rate toggle and delayed second pair
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_ok) begin
            phase_a <= 1'b0; // [R24]
            phase_c <= 1'b0;
            ph_cnt  <= `PHASE_RESET;
        end else begin
            if (tick) begin
                phase_a <= ~phase_a; // [R2]
                ph_cnt  <= phase_i; // [R4] [R5] new phase takes effect at the next tick
            end else if (ph_cnt != `PHASE_RESET) begin
                ph_cnt <= ph_cnt - 1'b1;
            end
            // zero phase follows the first pair on the tick itself
            // limitation: a phase longer than one tick period is reloaded before it expires, so the second pair stops toggling
            if (ph_cnt == `PHASE_LAST || (tick && phase_i == `PHASE_RESET)) begin
                phase_c <= tick ? ~phase_a : phase_a; // [R3] [R4]
            end
        end
    end

    // dead time leg ab
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_ok) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            cnt_ab <= `DEAD_RESET;
        end else if (a_q != phase_a || b_q != ~phase_a) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            if (cnt_ab >= dead_ab) begin
                a_q <= phase_a; // [R1] [R20]
                b_q <= ~phase_a;
                cnt_ab <= `DEAD_RESET;
            end else begin
                cnt_ab <= cnt_ab + 1'b1;
            end
        end
    end

    // dead time leg cd
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_ok) begin
            c_q <= 1'b0;
            d_q <= 1'b0;
            cnt_cd <= `DEAD_RESET;
        end else if (c_q != phase_c || d_q != ~phase_c) begin
            c_q <= 1'b0;
            d_q <= 1'b0;
            if (cnt_cd >= dead_cd) begin
                c_q <= phase_c; // [R3] [R20]
                d_q <= ~phase_c;
                cnt_cd <= `DEAD_RESET;
            end else begin
                cnt_cd <= cnt_cd + 1'b1;
            end
        end
    end

    // outputs gated by fault inputs the same cycle, then registered
    // limitation: true async kill is the pad's job; here it is one edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bridge_a_drive_o <= 1'b0;
            bridge_b_drive_o <= 1'b0;
            bridge_c_drive_o <= 1'b0;
            bridge_d_drive_o <= 1'b0;
        end else begin
            bridge_a_drive_o <= gate_ok(a_q, run_ok, hard_fault, overcurrent_i); // [R10]
            bridge_b_drive_o <= gate_ok(b_q, run_ok, hard_fault, overcurrent_i); // [R10]
            bridge_c_drive_o <= gate_ok(c_q, run_ok, hard_fault, overcurrent_i); // [R10]
            bridge_d_drive_o <= gate_ok(d_q, run_ok, hard_fault, overcurrent_i); // [R10]
        end
    end

    // sync pin copy of the internal tick
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_out_o <= 1'b0;
        end else begin
            sync_out_o <= osc_tick_i; // [R15]
        end
    end

    // sync pin direction; released while an external master drives it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_oe_n_o <= 1'b1;
        end else begin
            sync_oe_n_o <= sync_is_input_i; // [R15] [R16]
        end
    end

    // ramp discharge follows whichever tick is in use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ramp_discharge_o <= 1'b0;
        end else begin
            ramp_discharge_o <= tick; // [R17]
        end
    end

    // pin pulled hard to ground only for reference loss or undervoltage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ss_pulldown_o <= 1'b0;
        end else begin
            ss_pulldown_o <= reference_low_i | undervoltage_lockout_i; // [R7]
        end
    end

    // tenfold sink for the whole soft stop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ss_sink10_o <= 1'b0;
        end else begin
            ss_sink10_o <= (next_state == ST_STOP); // [R8]
        end
    end

    // source current whenever not stopping and not pulled down
    // one source covers both the held-low disable and the soft start ramp
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ss_source_o <= 1'b0;
        end else begin
            ss_source_o <= (next_state != ST_STOP) &
                           ~(reference_low_i | undervoltage_lockout_i); // [R11] [R13]
        end
    end

    // clamp always tracks the pin; it only bites while the pin is low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ea_clamp_o <= 1'b1;
        end else begin
            ea_clamp_o <= 1'b1; // [R14]
        end
    end

    // low supply current only in undervoltage, never for other disables
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_power_o <= 1'b0;
        end else begin
            low_power_o <= undervoltage_lockout_i; // [R12]
        end
    end

    // reference stays up through every disable but undervoltage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reference_enable_o <= 1'b1;
        end else begin
            reference_enable_o <= ~undervoltage_lockout_i; // [R19]
        end
    end

endmodule

/* File: bench/psb_pwm_assertions.sv */
// port checker for the phase-shift bridge pwm core
// bound into the core from the bench top; one clock domain
`timescale 1ns/1ps
module psb_pwm_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_tick_i,
    input wire logic sync_is_input_i,
    input wire logic softstart_low_i,
    input wire logic reference_low_i,
    input wire logic undervoltage_lockout_i,
    input wire logic overcurrent_i,
    input wire logic bridge_a_drive_o,
    input wire logic bridge_b_drive_o,
    input wire logic bridge_c_drive_o,
    input wire logic bridge_d_drive_o,
    input wire logic sync_out_o,
    input wire logic sync_oe_n_o,
    input wire logic ss_pulldown_o,
    input wire logic ss_sink10_o,
    input wire logic low_power_o,
    input wire logic reference_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // any gate on; only the run state drives, so this doubles as a run flag
    wire drv = bridge_a_drive_o | bridge_b_drive_o | bridge_c_drive_o | bridge_d_drive_o;
    wire fault = softstart_low_i | reference_low_i | undervoltage_lockout_i | overcurrent_i;
    kill_on_fault_a: assert property (fault |=> !drv)
        else $error("gate left on after a fault");
    leg_ab_gap_a: assert property (!(bridge_a_drive_o && bridge_b_drive_o))
        else $error("first leg both gates on");
    leg_cd_gap_a: assert property (!(bridge_c_drive_o && bridge_d_drive_o))
        else $error("second leg both gates on");
    sync_drive_a: assert property (!sync_is_input_i && osc_tick_i |=> sync_out_o && !sync_oe_n_o)
        else $error("sync pin not copying the tick");
    uv_shutdown_a: assert property (undervoltage_lockout_i |=> low_power_o && !reference_enable_o)
        else $error("undervoltage without low power");
    ref_pull_a: assert property (reference_low_i |=> ss_pulldown_o && reference_enable_o)
        else $error("reference loss without pull down");
    normal_power_a: assert property (!undervoltage_lockout_i |=> !low_power_o)
        else $error("low power outside undervoltage");
    stop_sink_a: assert property (overcurrent_i && drv && !softstart_low_i |=> ss_sink10_o)
        else $error("no soft stop sink on overcurrent");
    cover property (fault ##1 !drv);
    cover property (overcurrent_i && drv);
    cover property (sync_is_input_i && drv);
endmodule

/* File: bench/gate_drive_model.sv */
// gate drive stage model: counts a and c gate turn-ons and flags leg overlap
// also an external sync master; the sync line is pulled low when it is idle
`timescale 1ns/1ps
module gate_drive_model (
    input  wire logic clk_i,
    input  wire logic ext_en_i,
    input  wire logic a_i,
    input  wire logic b_i,
    input  wire logic c_i,
    input  wire logic d_i,
    output logic      sync_o = 1'b0,
    output int        rise_a_o = 0,
    output int        rise_c_o = 0,
    output logic      overlap_o = 1'b0
);
    logic pa = 1'b0;
    logic pc = 1'b0;
    int   cnt = 0;
    // overlap would short a half-bridge, so it is latched for the bench
    always @(posedge clk_i) begin
        pa <= a_i;
        pc <= c_i;
        rise_a_o <= rise_a_o + int'(a_i && !pa);
        rise_c_o <= rise_c_o + int'(c_i && !pc);
        if ((a_i && b_i) || (c_i && d_i)) overlap_o <= 1'b1;
        cnt <= (cnt == 15) ? 0 : cnt + 1;
        sync_o <= #1 ext_en_i && (cnt == 0);
    end
endmodule

/* File: bench/test_phase_shift_bridge_pwm.sv */
// self-checking bench for the phase-shift bridge pwm core
// gate drive model on the far side; port checker bound in below
`timescale 1ns/1ps
`include "psb_pwm_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_phase_shift_bridge_pwm;
    logic clk_i = 0, rst_n_i = 0, osc_tick_i = 0, sync_is_input_i = 0, adaptive_full_i = 1;
    logic [`PHASE_W-1:0] phase_i = 8'h03;
    logic [`DEAD_W-1:0]  leg1_dead_time_i = 8'h00, leg2_dead_time_i = 8'h02;
    logic [1:0]          load_level_i = 2'h3;
    logic softstart_low_i = 0, reference_low_i = 0, undervoltage_lockout_i = 0, overcurrent_i = 0;
    logic error_amp_low_i = 0, error_amp_high_i = 0, ext_en = 0, ext_sync, overlap;
    logic bridge_a_drive_o, bridge_b_drive_o, bridge_c_drive_o, bridge_d_drive_o, sync_out_o;
    logic sync_oe_n_o, ss_pulldown_o, ss_source_o, ss_sink10_o, ea_clamp_o, ramp_discharge_o;
    logic low_power_o, reference_enable_o;
    int   mismatches = 0, n_compared = 0, rise_a, rise_c, cnt = 0, n, m;
    // shared sync wire: core drives while enabled, else external master or pull-down
    wire logic sync_in_i = sync_oe_n_o ? ext_sync : sync_out_o;
    phase_shift_bridge_pwm phase_shift_bridge_pwm_inst (.clk_i, .rst_n_i, .osc_tick_i,
        .sync_in_i, .sync_is_input_i, .phase_i, .leg1_dead_time_i, .leg2_dead_time_i,
        .adaptive_full_i, .load_level_i, .softstart_low_i, .reference_low_i,
        .undervoltage_lockout_i, .overcurrent_i, .error_amp_low_i, .error_amp_high_i,
        .bridge_a_drive_o, .bridge_b_drive_o, .bridge_c_drive_o, .bridge_d_drive_o, .sync_out_o,
        .sync_oe_n_o, .ss_pulldown_o, .ss_source_o, .ss_sink10_o, .ea_clamp_o,
        .ramp_discharge_o, .low_power_o, .reference_enable_o);
    gate_drive_model gate_drive_model_inst (.clk_i, .ext_en_i(ext_en), .a_i(bridge_a_drive_o),
        .b_i(bridge_b_drive_o), .c_i(bridge_c_drive_o), .d_i(bridge_d_drive_o),
        .sync_o(ext_sync), .rise_a_o(rise_a), .rise_c_o(rise_c), .overlap_o(overlap));
    always #12.5 clk_i = ~clk_i;
    // internal oscillator: one-cycle tick every 10 clocks
    always @(posedge clk_i) begin
        cnt <= (cnt == 9) ? 0 : cnt + 1;
        osc_tick_i <= #1 (cnt == 9);
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // no-load latch starts off, so each run needs a high pulse first
    task automatic arm();
        error_amp_high_i = 1'b1;
        step(2);
        error_amp_high_i = 1'b0;
    endtask
    task automatic run_check();
        arm();
        step(60);
        n = rise_a;
        m = rise_c;
        step(200);
        `CHK(rise_a - n, 10)
        `CHK(rise_c - m, 10)
        @(posedge bridge_a_drive_o);
        #1;
        n = 0;
        while (!bridge_c_drive_o && n < 50) begin
            step(1);
            n++;
        end
        `CHK(n, 3)
        @(posedge osc_tick_i);
        step(9);
        `CHK(bridge_a_drive_o, !bridge_b_drive_o)
        `CHK(bridge_c_drive_o, bridge_a_drive_o)
        `CHK(overlap, 1'b0)
        error_amp_low_i = 1'b1;
        step(3);
        `CHK(bridge_a_drive_o | bridge_b_drive_o, 1'b0)
        error_amp_low_i = 1'b0;
        step(40);
        `CHK(bridge_a_drive_o | bridge_b_drive_o, 1'b0)
    endtask
    // both-low gap from the fall of b to the rise of a, in cycles
    task automatic gap();
        @(negedge bridge_b_drive_o);
        #1;
        n = 0;
        while (!bridge_a_drive_o && n < 50) begin
            step(1);
            n++;
        end
    endtask
    // first leg dead time fixed, then scaled to a quarter at peak load
    task automatic dead_check();
        arm();
        leg1_dead_time_i = 8'h04;
        adaptive_full_i = 1'b0;
        step(60);
        gap();
        `CHK(n, 4)
        adaptive_full_i = 1'b1;
        step(60);
        gap();
        `CHK(n, 1)
        `CHK(overlap, 1'b0)
        leg1_dead_time_i = 8'h00;
    endtask
    // one fault at a time: overcurrent, undervoltage, reference loss, disable
    task automatic fault_check();
        logic [3:0] f;
        for (int i = 0; i < 4; i++) begin
            arm();
            step(60);
            `CHK(bridge_a_drive_o | bridge_b_drive_o, 1'b1)
            f = 4'h1 << i;
            {softstart_low_i, reference_low_i, undervoltage_lockout_i, overcurrent_i} = f;
            step(2);
            `CHK({bridge_a_drive_o, bridge_b_drive_o, bridge_c_drive_o, bridge_d_drive_o}, 4'h0)
            `CHK(ss_pulldown_o, f[1] | f[2])
            `CHK(low_power_o, f[1])
            `CHK(reference_enable_o, !f[1])
            `CHK(ss_sink10_o, f[0])
            {softstart_low_i, reference_low_i, undervoltage_lockout_i, overcurrent_i} = 4'h8;
            step(2);
            `CHK(ss_source_o, 1'b1)
            `CHK(ss_sink10_o, 1'b0)
            `CHK(ea_clamp_o, 1'b1)
            softstart_low_i = 1'b0;
        end
    endtask
    task automatic sync_check();
        sync_is_input_i = 1'b1;
        ext_en = 1'b1;
        step(40);
        `CHK(sync_oe_n_o, 1'b1)
        n = 0;
        m = rise_a;
        repeat (320) begin
            step(1);
            n += int'(ramp_discharge_o);
        end
        `CHK(n, 20)
        `CHK(rise_a - m, 10)
        sync_is_input_i = 1'b0;
        ext_en = 1'b0;
        step(20);
        `CHK(sync_oe_n_o, 1'b0)
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        step(10);
        rst_n_i = 1'b1;
        step(2);
        run_check();
        dead_check();
        fault_check();
        sync_check();
        stop_test();
    end
    // watchdog well past the roughly 1150 cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end
endmodule
bind phase_shift_bridge_pwm psb_pwm_assertions psb_pwm_assertions_inst (.clk_i, .rst_n_i,
    .osc_tick_i, .sync_is_input_i, .softstart_low_i, .reference_low_i, .undervoltage_lockout_i,
    .overcurrent_i, .bridge_a_drive_o, .bridge_b_drive_o, .bridge_c_drive_o, .bridge_d_drive_o,
    .sync_out_o, .sync_oe_n_o, .ss_pulldown_o, .ss_sink10_o, .low_power_o, .reference_enable_o);
